/* File: logic/fmt_cmd_defs.svh */
// constants for the format id / format gate command handler
// assumes byte-wide framed host link, 100 MHz clock
`ifndef FMT_CMD_DEFS_SVH
`define FMT_CMD_DEFS_SVH

`define CMD_START_BYTE     8'haa
`define STAT_START_BYTE    8'hbb
`define CAT_FACTORY        8'h0f
`define OP_FULL_RESET      8'h01
`define OP_READ_ID         8'h02
`define OP_GATE            8'h03
`define GATE_CLEAR_VAL     8'h00
`define GATE_SET_VAL       8'h01
`define REPLY_KIND_ID      8'h60
`define RES_OK_HI          8'h00
`define RES_OK_LO          8'h00
`define RES_TAG_MISS_HI    8'h00
`define RES_TAG_MISS_LO    8'h71
`define GATE_WORD_SET      32'h0000_0001
`define GATE_WORD_ERASED   32'h0fff_ffff
`define TAG_ID_ERASED      32'hffff_ffff
`define CRC_POLY           16'h8408
`define CRC_INIT           16'h0000
`define UNIT_ADDR_RST      8'h01
`define ID_LEN             3'd4
`define REPLY_ID_LEN       4'd9
`define REPLY_STAT_LEN     4'd6
`define TAG_MISS_GAP_NS    1000
`define TAG_MISS_GAP_CYC   (((`TAG_MISS_GAP_NS) + 9) / 10)

`endif

/* File: logic/fmt_cmd_pkg.sv */
// types for the format id / format gate command handler
// assumes fmt_cmd_defs.svh is on the include path
package fmt_cmd_pkg;
  typedef logic [7:0] byte_t;

  // storage write request toward nonvolatile memory
  typedef struct packed {
    logic        gate_we;
    logic [31:0] gate_word;
    logic        tag_we;
    logic [31:0] tag_word;
  } store_wr_s;

  typedef enum logic [2:0] {
    P_START, P_ADDR, P_CAT, P_OP, P_PARAM
  } parse_e;
endpackage : fmt_cmd_pkg

/* File: logic/crc_acc.sv */
// running 16-bit integrity checksum over transmitted bytes
// assumes one byte per enable cycle, cleared before each frame
`timescale 1ns/1ps
`include "fmt_cmd_defs.svh"
module crc_acc
  import fmt_cmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        clear_in,
  input  wire logic        add_in,
  input  wire byte_t       data_in,
  output logic      [15:0] crc_out
);
  // ==========================================================
  // byte update, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input byte_t d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_step

  wire logic [15:0] crc_nxt = clear_in ? `CRC_INIT : (add_in ? crc_step(crc_out, data_in) : crc_out);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) crc_out <= `CRC_INIT;
    else if (ce_in) crc_out <= crc_nxt;
  end
endmodule : crc_acc

/* File: logic/fmt_cmd_handler.sv */
// format id read and format gate command handler, byte-stream framed host link
// assumes bytes arrive as one-cycle strobes synchronous to clk_in and tx_ready_in paces the reply
`timescale 1ns/1ps
`include "fmt_cmd_defs.svh"
module fmt_cmd_handler
  import fmt_cmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire byte_t       unit_addr_in,
  input  wire logic        rx_valid_in,
  input  wire byte_t       rx_data_in,
  input  wire logic        tx_ready_in,
  input  wire logic [31:0] stored_id_in,
  input  wire logic [31:0] stored_gate_in,
  input  wire logic        tag_read_in,
  input  wire logic        reset_done_in,
  output logic             tx_valid_out,
  output byte_t            tx_data_out,
  output logic             tx_last_out,
  output store_wr_s        store_wr_out,
  output logic             full_reset_req_out,
  output logic             tag_wanted_out,
  output logic             gate_state_out
);
  // ==========================================================
  // command parser
  parse_e      pstate_r;
  byte_t       op_r;
  logic        addr_ok_r;
  logic        cat_ok_r;

  // tag the action that a completed header or parameter byte starts
  wire logic hdr_done   = rx_valid_in && (pstate_r == P_OP);
  wire logic frame_ours = addr_ok_r && cat_ok_r;
  wire logic go_read    = hdr_done && frame_ours && (rx_data_in == `OP_READ_ID);
  wire logic go_reset   = hdr_done && frame_ours && (rx_data_in == `OP_FULL_RESET);
  wire logic need_param = hdr_done && frame_ours && (rx_data_in == `OP_GATE);
  wire logic param_in   = rx_valid_in && (pstate_r == P_PARAM);
  wire logic go_set     = param_in && (rx_data_in == `GATE_SET_VAL);
  wire logic go_clear   = param_in && (rx_data_in == `GATE_CLEAR_VAL);

  // trailing check bytes are optional, so after the last field the parser simply hunts for a new start byte
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pstate_r  <= P_START;
      op_r      <= 8'h00;
      addr_ok_r <= 1'b0;
      cat_ok_r  <= 1'b0;
    end else if (ce_in && rx_valid_in) begin
      case (pstate_r)
        P_START: if (rx_data_in == `CMD_START_BYTE) pstate_r <= P_ADDR;
        P_ADDR: begin
          addr_ok_r <= (rx_data_in == unit_addr_in);
          pstate_r  <= P_CAT;
        end
        P_CAT: begin
          cat_ok_r <= (rx_data_in == `CAT_FACTORY);
          pstate_r <= P_OP;
        end
        P_OP: begin
          op_r     <= rx_data_in;
          pstate_r <= need_param ? P_PARAM : P_START;
        end
        P_PARAM: pstate_r <= P_START;
        default: pstate_r <= P_START;
      endcase
    end
  end

  // ==========================================================
  // format gate state and storage writes
  logic gate_set_r;
  logic tag_seen_r;
  logic gate_loaded_r;

  wire logic tag_missing = gate_loaded_r && !gate_set_r && !tag_seen_r;

  // gate word is caught from storage on the first enabled cycle after reset release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_set_r    <= 1'b1;
      tag_seen_r    <= 1'b0;
      gate_loaded_r <= 1'b0;
      store_wr_out  <= '0;
    end else if (ce_in) begin
      store_wr_out <= '0;
      if (!gate_loaded_r) begin
        gate_loaded_r <= 1'b1;
        gate_set_r    <= (stored_gate_in == `GATE_WORD_SET);
      end
      if (go_set) begin
        gate_set_r             <= 1'b1;
        store_wr_out.gate_we   <= 1'b1;
        store_wr_out.gate_word <= `GATE_WORD_SET;
        store_wr_out.tag_we    <= 1'b1;
        store_wr_out.tag_word  <= `TAG_ID_ERASED;
      end else if (go_clear) begin
        gate_set_r             <= 1'b0;
        tag_seen_r             <= 1'b0;
        store_wr_out.gate_we   <= 1'b1;
        store_wr_out.gate_word <= `GATE_WORD_ERASED;
      end else if (tag_read_in && !gate_set_r) begin
        tag_seen_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // reply framer
  typedef enum logic [1:0] {R_IDLE, R_ID, R_STAT} reply_e;
  reply_e      rstate_r;
  logic [3:0]  ridx_r;
  byte_t       rres_lo_r;
  logic [31:0] id_r;
  logic [$clog2(`TAG_MISS_GAP_CYC+1)-1:0] gap_r;
  logic [15:0] crc_val;

  // repeated tag-missing reports are spaced so a stalled host is not flooded
  wire logic gap_done  = (gap_r == '0);
  wire logic want_miss = tag_missing && gap_done;
  wire logic busy      = (rstate_r != R_IDLE);
  wire logic last_idx  = (rstate_r == R_ID) ? (ridx_r == `REPLY_ID_LEN - 4'd1)
                                            : (ridx_r == `REPLY_STAT_LEN - 4'd1);
  wire logic tx_take   = tx_valid_out && tx_ready_in;

  // byte picked for the current reply slot
  function automatic byte_t reply_byte(input reply_e k, input logic [3:0] i, input byte_t a,
                                       input logic [31:0] id, input byte_t lo, input logic [15:0] c);
    byte_t b;
    b = 8'h00;
    if (k == R_ID) begin
      case (i)
        4'd0: b = `CMD_START_BYTE;
        4'd1: b = a;
        4'd2: b = `REPLY_KIND_ID;
        4'd3: b = id[31:24];
        4'd4: b = id[23:16];
        4'd5: b = id[15:8];
        4'd6: b = id[7:0];
        4'd7: b = c[15:8];
        default: b = c[7:0];
      endcase
    end else begin
      case (i)
        4'd0: b = `STAT_START_BYTE;
        4'd1: b = a;
        4'd2: b = `RES_OK_HI;
        4'd3: b = lo;
        4'd4: b = c[15:8];
        default: b = c[7:0];
      endcase
    end
    return b;
  endfunction : reply_byte

  wire logic  slot_is_crc = (rstate_r == R_ID) ? (ridx_r >= 4'd7) : (ridx_r >= 4'd4);
  wire byte_t next_byte   = reply_byte(rstate_r, ridx_r, unit_addr_in, id_r, rres_lo_r, crc_val);

  // checksum runs over every non-check byte as it leaves
  crc_acc u_crc (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .clear_in (!busy),
    .add_in   (tx_take && !slot_is_crc),
    .data_in  (tx_data_out),
    .crc_out  (crc_val)
  );

  // one reply in flight; a request that lands while busy is dropped, the host must wait
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rstate_r  <= R_IDLE;
      ridx_r    <= 4'd0;
      rres_lo_r <= 8'h00;
      id_r      <= 32'h0000_0000;
      gap_r     <= '0;
    end else if (ce_in) begin
      if (!gap_done) gap_r <= gap_r - 1'b1;
      case (rstate_r)
        R_IDLE: begin
          ridx_r <= 4'd0;
          if (go_read) begin
            id_r     <= stored_id_in;
            rstate_r <= R_ID;
          end else if (reset_done_in) begin
            rres_lo_r <= `RES_OK_LO;
            rstate_r  <= R_STAT;
          end else if (want_miss) begin
            rres_lo_r <= `RES_TAG_MISS_LO;
            rstate_r  <= R_STAT;
            gap_r     <= ($bits(gap_r))'(`TAG_MISS_GAP_CYC);
          end
        end
        R_ID, R_STAT: if (tx_take) begin
          ridx_r <= ridx_r + 4'd1;
          if (tx_last_out) rstate_r <= R_IDLE;
        end
        default: rstate_r <= R_IDLE;
      endcase
    end
  end

  // registered transmit byte; reloaded after every accepted byte except the last, which drops tx_valid_out instead
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
      tx_last_out  <= 1'b0;
    end else if (ce_in) begin
      if (busy && (!tx_valid_out || tx_take) && !(tx_take && tx_last_out)) begin
        tx_valid_out <= !(tx_take && last_idx) || 1'b0;
        tx_data_out  <= tx_take ? reply_byte(rstate_r, ridx_r + 4'd1, unit_addr_in, id_r, rres_lo_r,
                                             crc_acc_peek(crc_val, tx_data_out, !slot_is_crc)) : next_byte;
        tx_last_out  <= tx_take ? ((rstate_r == R_ID) ? (ridx_r + 4'd1 == `REPLY_ID_LEN - 4'd1)
                                                      : (ridx_r + 4'd1 == `REPLY_STAT_LEN - 4'd1))
                                : last_idx;
      end else if (tx_take) begin
        tx_valid_out <= 1'b0;
        tx_last_out  <= 1'b0;
      end
    end
  end

  // checksum as it will stand once the byte now leaving has been added
  function automatic logic [15:0] crc_acc_peek(input logic [15:0] c, input byte_t d, input logic add);
    logic [15:0] x;
    x = c;
    if (add) begin
      x = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
        x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
      end
    end
    return x;
  endfunction : crc_acc_peek

  // ==========================================================
  // status outputs; the gate command itself never starts the framer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      full_reset_req_out <= 1'b0;
      tag_wanted_out     <= 1'b0;
      gate_state_out     <= 1'b1;
    end else if (ce_in) begin
      full_reset_req_out <= go_reset;
      tag_wanted_out     <= tag_missing;
      gate_state_out     <= gate_set_r;
    end
  end
endmodule : fmt_cmd_handler

/* File: sim/fmt_cmd_handler_chk.sv */
// port assertions for the format id and gate handler
// assumes it is bound onto fmt_cmd_handler with ce_in held high
`timescale 1ns/1ps
module fmt_cmd_handler_chk
  import fmt_cmd_pkg::*;
(
  input wire logic      clk_in,
  input wire logic      rst_b_in,
  input wire logic      tx_ready_in,
  input wire byte_t     unit_addr_in,
  input wire logic      tx_valid_out,
  input wire byte_t     tx_data_out,
  input wire logic      tx_last_out,
  input wire store_wr_s store_wr_out,
  input wire logic      tag_wanted_out,
  input wire logic      gate_state_out
);
  // =====================================
  // byte position of the reply in flight
  logic [3:0] idx_r;
  logic       id_r;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx_r <= 4'h0;
      id_r  <= 1'b0;
    end else if (tx_valid_out && tx_ready_in) begin
      idx_r <= tx_last_out ? 4'h0 : idx_r + 4'h1;
      if (idx_r == 4'h0) id_r <= (tx_data_out == 8'haa);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence set_wr;
    store_wr_out.gate_we && store_wr_out.gate_word == 32'h0000_0001;
  endsequence
  sequence clr_wr;
    store_wr_out.gate_we && store_wr_out.gate_word == 32'h0fff_ffff;
  endsequence
  head_byte_a: assert property (
    tx_valid_out && idx_r == 4'h0 |-> tx_data_out inside {8'haa, 8'hbb})
    else $error("reply head byte wrong");
  addr_slot_a: assert property (
    tx_valid_out && idx_r == 4'h1 |-> tx_data_out == unit_addr_in)
    else $error("reply address wrong");
  kind_slot_a: assert property (
    tx_valid_out && idx_r == 4'h2 |-> tx_data_out == (id_r ? 8'h60 : 8'h00))
    else $error("reply kind byte wrong");
  frame_len_a: assert property (
    tx_valid_out && tx_last_out |-> idx_r == (id_r ? 4'h8 : 4'h5))
    else $error("reply length wrong");
  byte_hold_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte not held");
  set_write_a: assert property (
    set_wr |-> store_wr_out.tag_we && store_wr_out.tag_word == 32'hffff_ffff
      ##[0:2] gate_state_out && !tag_wanted_out)
    else $error("gate set handling wrong");
  clr_write_a: assert property (
    clr_wr |-> ##[0:2] tag_wanted_out && !gate_state_out)
    else $error("gate clear handling wrong");
  want_gate_a: assert property (
    tag_wanted_out |-> !gate_state_out)
    else $error("tag wanted while gate set");
endmodule : fmt_cmd_handler_chk

bind fmt_cmd_handler fmt_cmd_handler_chk chk (.clk_in, .rst_b_in, .tx_ready_in, .unit_addr_in,
  .tx_valid_out, .tx_data_out, .tx_last_out, .store_wr_out, .tag_wanted_out, .gate_state_out);

/* File: sim/host_model.sv */
// host end of the framed command link
// assumes byte strobes sampled on the rising edge
`timescale 1ns/1ps
module host_model
  import fmt_cmd_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  tx_valid_in,
  input  wire byte_t tx_data_in,
  output logic       rx_valid_out,
  output byte_t      rx_data_out,
  output logic       tx_ready_out
);
  // =====================================
  // reply capture and command sender
  byte_t got_q[$];
  bit    slow = 1'b0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b0;
  end
  // slow host halves the accept rate to stretch replies
  always @(negedge clk_in) tx_ready_out <= slow ? !tx_ready_out : 1'b1;
  always @(posedge clk_in) if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
  // idle data is inverted so a stale byte never looks valid
  task automatic send(input byte_t f[$]);
    foreach (f[i]) begin
      @(negedge clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out  <= f[i];
      @(negedge clk_in);
      rx_valid_out <= 1'b0;
      rx_data_out  <= ~f[i];
    end
  endtask : send
endmodule : host_model

/* File: sim/test_fmt_cmd_handler.sv */
// self-checking bench for the format id and gate handler
// assumes host_model and the bound checker are compiled first
`timescale 1ns/1ps
module test_fmt_cmd_handler
  import fmt_cmd_pkg::*;
;
  // =====================================
  // stimulus and design hookup
  logic        clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1;
  logic        tag_read_in = 1'b0, reset_done_in = 1'b0;
  logic [31:0] stored_id_in = 32'h9332_eff6, stored_gate_in = 32'h0000_0001;
  byte_t       unit_addr_in = 8'h01, rx_data_in, tx_data_out;
  logic        rx_valid_in, tx_ready_in, tx_valid_out, tx_last_out;
  logic        full_reset_req_out, tag_wanted_out, gate_state_out;
  store_wr_s   store_wr_out, wr_seen;
  int          bad_count = 0, num_checks = 0, req_n = 0;
  always #5 clk_in = ~clk_in;
  fmt_cmd_handler dut (.clk_in, .rst_b_in, .ce_in, .unit_addr_in, .rx_valid_in, .rx_data_in,
    .tx_ready_in, .stored_id_in, .stored_gate_in, .tag_read_in, .reset_done_in, .tx_valid_out,
    .tx_data_out, .tx_last_out, .store_wr_out, .full_reset_req_out, .tag_wanted_out, .gate_state_out);
  host_model host (.clk_in, .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in), .tx_ready_out(tx_ready_in));
  // latch write pulses, they last one cycle only
  always @(posedge clk_in) begin
    if (store_wr_out.gate_we) wr_seen <= store_wr_out;
    if (full_reset_req_out) req_n <= req_n + 1;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // reflected check sum over every byte ahead of it
  function automatic logic [15:0] crc(input byte_t f[$]);
    logic [15:0] c = 16'h0000;
    foreach (f[i]) begin
      c ^= {8'h00, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction : crc
  task automatic reply(input string n, input byte_t f[$]);
    logic [15:0] c;
    int          k;
    c = crc(f);
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    k = 0;
    while (host.got_q.size() < f.size() && k < 400) begin
      @(negedge clk_in);
      k++;
    end
    chk(n, f.size(), host.got_q.size());
    foreach (f[i]) if (i < host.got_q.size()) chk(n, f[i], host.got_q[i]);
    host.got_q.delete();
  endtask : reply
  task automatic quiet(input int n);
    repeat (n) @(negedge clk_in);
    chk("quiet", 0, host.got_q.size());
  endtask : quiet
  // =====================================
  // scenarios
  task automatic t_read_id();
    host.slow = 1'b1;
    host.send('{8'haa, 8'h01, 8'h0f, 8'h02, 8'h01, 8'h51});
    reply("id", '{8'haa, 8'h01, 8'h60, 8'h93, 8'h32, 8'hef, 8'hf6});
    host.slow = 1'b0;
  endtask : t_read_id
  task automatic t_reset();
    host.send('{8'haa, 8'h01, 8'h0f, 8'h01});
    quiet(4);
    chk("req", 1, req_n);
    @(negedge clk_in) reset_done_in = 1'b1;
    @(negedge clk_in) reset_done_in = 1'b0;
    reply("done", '{8'hbb, 8'h01, 8'h00, 8'h00});
  endtask : t_reset
  task automatic t_gate();
    host.send('{8'haa, 8'h01, 8'h0f, 8'h03, 8'h00});
    // gate flag and write latch both settle one edge after the parameter byte
    repeat (2) @(negedge clk_in);
    chk("want", 1, tag_wanted_out);
    chk("clr", 32'h0fff_ffff, wr_seen.gate_word);
    reply("miss", '{8'hbb, 8'h01, 8'h00, 8'h71});
    reply("again", '{8'hbb, 8'h01, 8'h00, 8'h71});
    @(negedge clk_in) tag_read_in = 1'b1;
    @(negedge clk_in) tag_read_in = 1'b0;
    quiet(150);
    host.send('{8'haa, 8'h01, 8'h0f, 8'h03, 8'h00});
    reply("miss", '{8'hbb, 8'h01, 8'h00, 8'h71});
    wr_seen = '0;
    host.send('{8'haa, 8'h01, 8'h0f, 8'h03, 8'h01, 8'h62, 8'h31});
    chk("set", 32'h0000_0001, wr_seen.gate_word);
    chk("tag", 32'hffff_ffff, wr_seen.tag_word);
    chk("want", 0, tag_wanted_out);
    chk("gate", 1, gate_state_out);
    quiet(150);
  endtask : t_gate
  task automatic t_other();
    wr_seen = '0;
    host.send('{8'haa, 8'h02, 8'h0f, 8'h02});
    host.send('{8'haa, 8'h01, 8'h0e, 8'h02});
    host.send('{8'haa, 8'h01, 8'h0f, 8'h03, 8'h02});
    host.send('{8'haa, 8'h02, 8'h0f, 8'h01});
    quiet(50);
    chk("odd", 0, wr_seen.gate_we);
    chk("req", 1, req_n);
    // with the clock enable low a full read command must leave no trace
    @(negedge clk_in) ce_in = 1'b0;
    host.send('{8'haa, 8'h01, 8'h0f, 8'h02});
    @(negedge clk_in) ce_in = 1'b1;
    quiet(50);
  endtask : t_other
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    t_read_id();
    t_reset();
    t_gate();
    t_other();
    summarize();
  end
  // hang guard, about fifteen times the expected run
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
endmodule : test_fmt_cmd_handler
